// ===== core/rref_framer.sv
// Host link framer: parses far register commands and builds replies, events and announcements.
`timescale 1ns/100ps
`include "rref_consts.svh"

module rref_framer #(
  parameter int PAYLOAD_MAX = 103,
  parameter int VALUE_BYTES = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output rref_pkg::rref_rd_cmd_s rd_cmd_o,
  output logic rd_cmd_valid_o,
  input wire logic rd_cmd_ready_i,
  output rref_pkg::rref_wr_cmd_s wr_cmd_o,
  output logic wr_cmd_valid_o,
  input wire logic wr_cmd_ready_i,
  input wire rref_pkg::rref_rd_rep_s rd_rep_i,
  input wire logic rd_rep_valid_i,
  output logic rd_rep_ready_o,
  input wire rref_pkg::rref_wr_rep_s wr_rep_i,
  input wire logic wr_rep_valid_i,
  output logic wr_rep_ready_o,
  input wire rref_pkg::rref_evt_s evt_i,
  input wire logic evt_valid_i,
  output logic evt_ready_o,
  input wire logic [7:0] pay_data_i,
  input wire logic pay_valid_i,
  output logic pay_ready_o,
  input wire logic startup_done_i,
  input wire logic ro_write_err_i,
  input wire logic brownout_i,
  input wire logic watchdog_i,
  input wire logic hw_fault_i
);

  if (PAYLOAD_MAX < 1 || PAYLOAD_MAX > 103 || VALUE_BYTES != 16) begin : g_param_check
    $error("rref_framer: unsupported payload or value size");
  end

  localparam logic [6:0] PAY_MAX = 7'(PAYLOAD_MAX);

  // Parser state.
  rref_pkg::rref_pstate_e pstate;
  logic [7:0] pbuf [0:`RREF_BUF_DEPTH-1];
  logic [7:0] premain;
  logic [7:0] plen;
  logic [7:0] pidx;
  logic rd_ok;
  logic wr_ok;
  logic cmd_bad;
  logic [7:0] ptype;
  logic [7:0] psize;

  assign ptype = pbuf[`RREF_O_TYPE];
  assign psize = pbuf[`RREF_O_CMD_SIZE];

  function automatic logic size_ok(input logic [7:0] s);
    size_ok = (s != 8'h00) && (s <= 8'(VALUE_BYTES));
  endfunction

  // A message too long to buffer is still counted through, then rejected.
  always_comb begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    cmd_bad = 1'b0;
    if (ptype == `RREF_T_RD_CMD) begin
      rd_ok = (plen == `RREF_L_RD_CMD) && size_ok(psize);
      cmd_bad = !rd_ok;
    end else if (ptype == `RREF_T_WR_CMD) begin
      wr_ok = (plen <= `RREF_L_MAX_CMD) && size_ok(psize)
              && (plen == `RREF_L_WR_CMD_BASE + psize);
      cmd_bad = !wr_ok;
    end
  end

  assign rx_ready_o = (pstate != rref_pkg::RREF_P_HOLD) && (pstate != rref_pkg::RREF_P_DECODE);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pstate <= rref_pkg::RREF_P_HUNT;
      premain <= 8'h00;
      plen <= 8'h00;
      pidx <= 8'h00;
      rd_cmd_valid_o <= 1'b0;
      wr_cmd_valid_o <= 1'b0;
    end else begin
      case (pstate)
        rref_pkg::RREF_P_HUNT: begin
          if (rx_valid_i && rx_data_i == `RREF_SOP) begin
            pstate <= rref_pkg::RREF_P_LEN;
          end
        end
        rref_pkg::RREF_P_LEN: begin
          if (rx_valid_i) begin
            plen <= rx_data_i;
            premain <= rx_data_i;
            pidx <= 8'h02;
            pstate <= (rx_data_i == 8'h00) ? rref_pkg::RREF_P_HUNT : rref_pkg::RREF_P_BODY;
          end
        end
        rref_pkg::RREF_P_BODY: begin
          if (rx_valid_i) begin
            pidx <= pidx + 8'h01;
            premain <= premain - 8'h01;
            if (premain == 8'h01) begin
              pstate <= rref_pkg::RREF_P_DECODE;
            end
          end
        end
        rref_pkg::RREF_P_DECODE: begin
          rd_cmd_valid_o <= rd_ok;
          wr_cmd_valid_o <= wr_ok;
          pstate <= (rd_ok || wr_ok) ? rref_pkg::RREF_P_HOLD : rref_pkg::RREF_P_HUNT;
        end
        rref_pkg::RREF_P_HOLD: begin
          if ((rd_cmd_valid_o && rd_cmd_ready_i) || (wr_cmd_valid_o && wr_cmd_ready_i)) begin
            rd_cmd_valid_o <= 1'b0;
            wr_cmd_valid_o <= 1'b0;
            pstate <= rref_pkg::RREF_P_HUNT;
          end
        end
        default: begin
          pstate <= rref_pkg::RREF_P_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < `RREF_BUF_DEPTH; i++) begin
        pbuf[i] <= 8'h00;
      end
    end else if (pstate == rref_pkg::RREF_P_BODY && rx_valid_i
                 && pidx < 8'(`RREF_BUF_DEPTH)) begin
      pbuf[pidx[4:0]] <= rx_data_i;
    end
  end

  always_comb begin
    rd_cmd_o.addr = {pbuf[5], pbuf[4], pbuf[3]};
    rd_cmd_o.off = pbuf[`RREF_O_CMD_OFF];
    rd_cmd_o.bank = pbuf[`RREF_O_CMD_BANK];
    rd_cmd_o.size = psize;
    wr_cmd_o.addr = rd_cmd_o.addr;
    wr_cmd_o.off = rd_cmd_o.off;
    wr_cmd_o.bank = rd_cmd_o.bank;
    wr_cmd_o.size = psize;
    for (int i = 0; i < 16; i++) begin
      wr_cmd_o.value[8*i +: 8] = pbuf[`RREF_O_CMD_VAL + i];
    end
  end

  // Announcement requests: bit order A0, E1, E4, EC, ED, EE; lowest goes first.
  logic [5:0] ann_pend;
  logic [5:0] ann_set;
  logic [5:0] ann_clr;
  logic [2:0] ann_pick;
  logic [2:0] ann_sel;

  assign ann_set = {hw_fault_i, watchdog_i, brownout_i, ro_write_err_i,
                    pstate == rref_pkg::RREF_P_DECODE && cmd_bad, startup_done_i};

  function automatic logic [7:0] ann_code(input logic [2:0] s);
    case (s)
      3'h0: ann_code = `RREF_ST_STARTUP;
      3'h1: ann_code = `RREF_ST_INVALID;
      3'h2: ann_code = `RREF_ST_RO_WRITE;
      3'h3: ann_code = `RREF_ST_BROWNOUT;
      3'h4: ann_code = `RREF_ST_WATCHDOG;
      3'h5: ann_code = `RREF_ST_HW_FAULT;
      default: ann_code = `RREF_ST_INVALID;
    endcase
  endfunction

  always_comb begin
    ann_pick = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (ann_pend[i]) begin
        ann_pick = 3'(i);
      end
    end
  end

  // A new request in the clearing cycle keeps its flag set.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ann_pend <= 6'h00;
    end else begin
      ann_pend <= (ann_pend & ~ann_clr) | ann_set;
    end
  end

  // Transmit framing.
  rref_pkg::rref_kind_e tx_kind;
  logic [6:0] tx_idx;
  logic [7:0] tx_len;
  logic tx_load;
  logic tx_last;
  logic tx_is_pay;
  logic rd_good;
  logic [6:0] evt_cnt;

  assign rd_good = (rd_rep_i.status == `RREF_ST_OK) && size_ok(rd_rep_i.size);
  assign evt_cnt = (evt_i.count > PAY_MAX) ? PAY_MAX : evt_i.count;

  always_comb begin
    case (tx_kind)
      rref_pkg::RREF_K_ANN: tx_len = `RREF_L_ANN;
      rref_pkg::RREF_K_RD: tx_len = rd_good ? `RREF_L_RD_REP_BASE + rd_rep_i.size
                                            : `RREF_L_RD_REP_ERR;
      rref_pkg::RREF_K_WR: tx_len = `RREF_L_WR_REP;
      rref_pkg::RREF_K_EVT: tx_len = `RREF_L_EVT_BASE + {1'b0, evt_cnt};
      default: tx_len = 8'h00;
    endcase
  end

  function automatic logic [7:0] rssi_clip(input logic [7:0] r);
    rssi_clip = r;
  endfunction

  always_comb begin
    tx_is_pay = (tx_kind == rref_pkg::RREF_K_EVT) && (tx_idx >= `RREF_O_EVT_PAY);
    tx_last = ({1'b0, tx_idx} == tx_len + 8'h01);
    tx_load = (tx_kind != rref_pkg::RREF_K_NONE) && (!tx_valid_o || tx_ready_i)
              && !(tx_is_pay && !pay_valid_i);
    pay_ready_o = tx_load && tx_is_pay;
    rd_rep_ready_o = tx_load && tx_last && tx_kind == rref_pkg::RREF_K_RD;
    wr_rep_ready_o = tx_load && tx_last && tx_kind == rref_pkg::RREF_K_WR;
    evt_ready_o = tx_load && tx_last && tx_kind == rref_pkg::RREF_K_EVT;
    ann_clr = 6'h00;
    if (tx_load && tx_last && tx_kind == rref_pkg::RREF_K_ANN) begin
      ann_clr[ann_sel] = 1'b1;
    end
  end

  // Byte at a given offset of the frame in flight.
  logic [7:0] next_byte;
  logic [7:0] rd_status;
  logic [6:0] vidx;

  assign rd_status = rd_good ? `RREF_ST_OK
                   : (rd_rep_i.status == `RREF_ST_OK ? `RREF_ST_INVALID : rd_rep_i.status);
  assign vidx = tx_idx - `RREF_O_RD_VAL;

  always_comb begin
    next_byte = 8'h00;
    case (tx_idx)
      7'h00: next_byte = `RREF_SOP;
      7'h01: next_byte = tx_len;
      default: begin
        case (tx_kind)
          rref_pkg::RREF_K_ANN: begin
            next_byte = (tx_idx == 7'h02) ? `RREF_T_ANN : ann_code(ann_sel);
          end
          rref_pkg::RREF_K_RD: begin
            case (tx_idx)
              7'h02: next_byte = `RREF_T_RD_REP;
              7'h03: next_byte = rd_status;
              7'h04: next_byte = rd_rep_i.addr[7:0];
              7'h05: next_byte = rd_rep_i.addr[15:8];
              7'h06: next_byte = rd_rep_i.addr[23:16];
              7'h07: next_byte = rssi_clip(rd_rep_i.rssi);
              7'h08: next_byte = rd_rep_i.off;
              7'h09: next_byte = rd_rep_i.bank;
              7'h0A: next_byte = rd_rep_i.size;
              default: next_byte = rd_rep_i.value[{vidx[3:0], 3'b000} +: 8];
            endcase
          end
          rref_pkg::RREF_K_WR: begin
            case (tx_idx)
              7'h02: next_byte = `RREF_T_WR_REP;
              7'h03: next_byte = wr_rep_i.status;
              7'h04: next_byte = wr_rep_i.addr[7:0];
              7'h05: next_byte = wr_rep_i.addr[15:8];
              7'h06: next_byte = wr_rep_i.addr[23:16];
              default: next_byte = rssi_clip(wr_rep_i.rssi);
            endcase
          end
          rref_pkg::RREF_K_EVT: begin
            case (tx_idx)
              7'h02: next_byte = `RREF_T_EVT;
              7'h03: next_byte = evt_i.addr[7:0];
              7'h04: next_byte = evt_i.addr[15:8];
              7'h05: next_byte = evt_i.addr[23:16];
              7'h06: next_byte = evt_i.rssi;
              default: next_byte = pay_data_i;
            endcase
          end
          default: next_byte = 8'h00;
        endcase
      end
    endcase
  end

  // Frame selection; the frame ends after its last byte, failed reads after power.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_kind <= rref_pkg::RREF_K_NONE;
      tx_idx <= 7'h00;
      ann_sel <= 3'h0;
    end else if (tx_kind == rref_pkg::RREF_K_NONE) begin
      tx_idx <= 7'h00;
      ann_sel <= ann_pick;
      if (ann_pend != 6'h00) begin
        tx_kind <= rref_pkg::RREF_K_ANN;
      end else if (rd_rep_valid_i) begin
        tx_kind <= rref_pkg::RREF_K_RD;
      end else if (wr_rep_valid_i) begin
        tx_kind <= rref_pkg::RREF_K_WR;
      end else if (evt_valid_i) begin
        tx_kind <= rref_pkg::RREF_K_EVT;
      end
    end else if (tx_load) begin
      tx_idx <= tx_idx + 7'h01;
      if (tx_last) begin
        tx_kind <= rref_pkg::RREF_K_NONE;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (tx_load) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= next_byte;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

endmodule

// ===== shared/rref_consts.svh
// Byte values, field offsets and lengths of the host link messages.
`ifndef RREF_CONSTS_SVH
`define RREF_CONSTS_SVH
`define RREF_SOP 8'hFB
`define RREF_T_RD_CMD 8'h06
`define RREF_T_WR_CMD 8'h07
`define RREF_T_RD_REP 8'h16
`define RREF_T_WR_REP 8'h17
`define RREF_T_EVT 8'h26
`define RREF_T_ANN 8'h27
`define RREF_L_RD_CMD 8'h07
`define RREF_L_WR_CMD_BASE 8'h07
`define RREF_L_MAX_CMD 8'h17
`define RREF_L_RD_REP_ERR 8'h06
`define RREF_L_RD_REP_BASE 8'h09
`define RREF_L_WR_REP 8'h06
`define RREF_L_EVT_BASE 8'h05
`define RREF_L_ANN 8'h02
`define RREF_ST_OK 8'h00
`define RREF_ST_INVALID 8'hE1
`define RREF_ST_STARTUP 8'hA0
`define RREF_ST_RO_WRITE 8'hE4
`define RREF_ST_BROWNOUT 8'hEC
`define RREF_ST_WATCHDOG 8'hED
`define RREF_ST_HW_FAULT 8'hEE
`define RREF_RSSI_INVALID 8'h7F
`define RREF_O_TYPE 5'h02
`define RREF_O_ADDR 5'h03
`define RREF_O_CMD_OFF 5'h06
`define RREF_O_CMD_BANK 5'h07
`define RREF_O_CMD_SIZE 5'h08
`define RREF_O_CMD_VAL 5'h09
`define RREF_O_RD_VAL 7'h0B
`define RREF_O_EVT_PAY 7'h07
`define RREF_BUF_DEPTH 25
`endif

// ===== shared/rref_pkg.sv
// Types shared by the host link framer and its users.
package rref_pkg;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] off;
    logic [7:0] bank;
    logic [7:0] size;
  } rref_rd_cmd_s;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] off;
    logic [7:0] bank;
    logic [7:0] size;
    logic [127:0] value;
  } rref_wr_cmd_s;
  typedef struct packed {
    logic [7:0] status;
    logic [23:0] addr;
    logic [7:0] rssi;
    logic [7:0] off;
    logic [7:0] bank;
    logic [7:0] size;
    logic [127:0] value;
  } rref_rd_rep_s;
  typedef struct packed {
    logic [7:0] status;
    logic [23:0] addr;
    logic [7:0] rssi;
  } rref_wr_rep_s;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] rssi;
    logic [6:0] count;
  } rref_evt_s;
  typedef enum logic [2:0] {
    RREF_P_HUNT = 3'b000,
    RREF_P_LEN = 3'b001,
    RREF_P_BODY = 3'b010,
    RREF_P_DECODE = 3'b011,
    RREF_P_HOLD = 3'b100
  } rref_pstate_e;
  typedef enum logic [2:0] {
    RREF_K_NONE = 3'b000,
    RREF_K_ANN = 3'b001,
    RREF_K_RD = 3'b010,
    RREF_K_WR = 3'b011,
    RREF_K_EVT = 3'b100
  } rref_kind_e;
endpackage

// ===== verif/rref_framer_checker.sv
// Concurrent checks on the ports of the host link framer.
`timescale 1ns/100ps
module rref_framer_checker (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rx_ready_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic rd_cmd_valid_o,
  input wire logic rd_cmd_ready_i,
  input wire logic wr_cmd_valid_o,
  input wire logic wr_cmd_ready_i,
  input wire rref_pkg::rref_wr_rep_s wr_rep_i,
  input wire logic wr_rep_ready_o,
  input wire logic [7:0] pay_data_i,
  input wire logic pay_valid_i,
  input wire logic pay_ready_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [7:0] left;
  logic at_len;
  logic take;
  assign take = tx_valid_o && tx_ready_i;
  // Counts each outgoing frame down from its length byte to find the next start.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      left <= 8'h00;
      at_len <= 1'b0;
    end else if (take) begin
      if (at_len) begin
        left <= tx_data_o;
        at_len <= 1'b0;
      end else if (left == 8'h00) begin
        at_len <= 1'b1;
      end else begin
        left <= left - 8'h01;
      end
    end
  end
  a_frame_start_byte: assert property (
      take && !at_len && left == 8'h00 |-> tx_data_o == 8'hFB)
    else $error("frame does not open with the start byte");
  a_length_in_range: assert property (
      take && at_len |-> tx_data_o inside {[8'h02:8'h6C]})
    else $error("length byte out of range");
  a_tx_stall_hold: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte changed while stalled");
  a_read_cmd_hold: assert property (
      rd_cmd_valid_o && !rd_cmd_ready_i |=> rd_cmd_valid_o)
    else $error("read command dropped before taken");
  a_read_cmd_drop: assert property (
      rd_cmd_valid_o && rd_cmd_ready_i |=> !rd_cmd_valid_o)
    else $error("read command held after taken");
  a_write_cmd_hold: assert property (
      wr_cmd_valid_o && !wr_cmd_ready_i |=> wr_cmd_valid_o)
    else $error("write command dropped before taken");
  a_parser_blocked: assert property (rd_cmd_valid_o || wr_cmd_valid_o |-> !rx_ready_o)
    else $error("parser takes bytes while a command is pending");
  a_wr_rssi_last: assert property (wr_rep_ready_o |=> !wr_rep_ready_o && tx_valid_o
      && tx_data_o == $past(wr_rep_i.rssi))
    else $error("write reply does not end with its power byte");
  a_payload_pass: assert property (
      pay_valid_i && pay_ready_o |=> tx_data_o == $past(pay_data_i))
    else $error("payload byte not passed through");
endmodule
bind rref_framer rref_framer_checker chk_u (.*);

// ===== verif/rref_host_model.sv
// Host side model: offers command bytes and accepts reply bytes, stalling on request.
`timescale 1ns/100ps
module rref_host_model (
  input wire logic clk_i,
  input wire logic rx_ready_i,
  input wire logic stall_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic tx_ready_o
);
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  always @(negedge clk_i) begin
    tx_ready_o <= stall_i ? 1'($urandom % 2) : 1'b1;
  end
  // Holds the byte until the rising edge at which the framer takes it.
  task automatic send(input logic [7:0] b);
    @(negedge clk_i);
    rx_data_o = b;
    rx_valid_o = 1'b1;
    #1;
    while (rx_ready_i !== 1'b1) begin
      @(negedge clk_i);
      #1;
    end
    @(posedge clk_i);
  endtask
  // A released line shows the inverse of its last byte.
  task automatic idle();
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
endmodule

// ===== verif/tb.sv
// Self-checking bench for the host link framer.
`timescale 1ns/100ps
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stall = 1'b0;
  logic [7:0] rx_data_i, tx_data_o, rs, sz;
  logic [7:0] pay_data_i = 8'h00;
  logic rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, pay_ready_o;
  logic rd_cmd_valid_o, wr_cmd_valid_o, rd_rep_ready_o, wr_rep_ready_o, evt_ready_o;
  logic rd_cmd_ready_i = 1'b0, wr_cmd_ready_i = 1'b0, rd_rep_valid_i = 1'b0;
  logic wr_rep_valid_i = 1'b0, evt_valid_i = 1'b0, pay_valid_i = 1'b0;
  logic startup_done_i = 1'b0, ro_write_err_i = 1'b0, brownout_i = 1'b0;
  logic watchdog_i = 1'b0, hw_fault_i = 1'b0;
  rref_pkg::rref_rd_cmd_s rd_cmd_o;
  rref_pkg::rref_wr_cmd_s wr_cmd_o;
  rref_pkg::rref_rd_rep_s rd_rep_i = '0;
  rref_pkg::rref_wr_rep_s wr_rep_i = '0;
  rref_pkg::rref_evt_s evt_i = '0;
  logic [23:0] ad;
  logic [127:0] val, m;
  logic [7:0] codes[5] = '{8'hA0, 8'hE4, 8'hEC, 8'hED, 8'hEE};
  logic [7:0] wst[2] = '{8'h00, 8'hE1};
  logic [7:0] wrs[2] = '{8'h80, 8'h7F};
  logic [7:0] exp_q[$];
  logic [7:0] v[$];
  int bad_count = 0;
  int check_count = 0;
  logic [5:0] hs;
  assign hs = {rd_cmd_valid_o, wr_cmd_valid_o, rd_rep_ready_o, wr_rep_ready_o, evt_ready_o,
    pay_ready_o};
  always #2.5 core_clk_i = ~core_clk_i;
  rref_framer dut_u (.*);
  rref_host_model host_u (.clk_i(core_clk_i), .rx_ready_i(rx_ready_o), .stall_i(stall),
    .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i));
  task automatic chk(input logic [175:0] seen, input logic [175:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  always @(posedge core_clk_i) begin
    if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (exp_q.size() == 0) chk(tx_data_o, 176'h1FF, "extra tx byte");
      else chk(tx_data_o, exp_q.pop_front(), "tx byte");
    end
  end
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    #1;
    while (hs[k] !== 1'b1 && n < 3000) begin
      @(negedge core_clk_i);
      #1;
      n++;
    end
    if (n >= 3000) chk(1'b0, 1'b1, "handshake");
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 3000) chk(1'b0, 1'b1, "frame drain");
    repeat (4) @(negedge core_clk_i);
  endtask
  task automatic frame(input logic [7:0] b[$]);
    foreach (b[i]) host_u.send(b[i]);
    host_u.idle();
  endtask
  task automatic rd_reply(input logic [7:0] st);
    exp_q = {8'hFB, (st == 8'h00) ? 8'h09 + sz : 8'h06, 8'h16, st};
    exp_q = {exp_q, ad[7:0], ad[15:8], ad[23:16], rs};
    if (st == 8'h00) begin
      exp_q = {exp_q, 8'h21, 8'h02, sz};
      for (int i = 0; i < sz; i++) exp_q.push_back(val[8*i +: 8]);
    end
    rd_rep_i = '{st, ad, rs, 8'h21, 8'h02, sz, val};
    rd_rep_valid_i = 1'b1;
    wait_hi(3);
    @(negedge core_clk_i);
    rd_rep_valid_i = 1'b0;
    drain();
  endtask
  task automatic event_out(input logic [6:0] cnt);
    int n;
    n = (cnt > 7'd103) ? 103 : int'(cnt);
    exp_q = {8'hFB, 8'(5 + n), 8'h26, ad[7:0], ad[15:8], ad[23:16], rs};
    evt_i = '{ad, rs, cnt};
    evt_valid_i = 1'b1;
    for (int i = 0; i < n; i++) begin
      pay_data_i = 8'($urandom);
      exp_q.push_back(pay_data_i);
      pay_valid_i = 1'b1;
      wait_hi(0);
      chk(evt_ready_o, i == n - 1, "event done");
      @(negedge core_clk_i);
    end
    pay_valid_i = 1'b0;
    pay_data_i = ~pay_data_i;
    evt_valid_i = 1'b0;
    drain();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h3203));
    repeat (3) @(negedge core_clk_i);
    rst_i = 1'b0;
    foreach (codes[i]) exp_q = {exp_q, 8'hFB, 8'h02, 8'h27, codes[i]};
    {startup_done_i, ro_write_err_i, brownout_i, watchdog_i, hw_fault_i} = 5'h1F;
    @(negedge core_clk_i);
    {startup_done_i, ro_write_err_i, brownout_i, watchdog_i, hw_fault_i} = 5'h00;
    drain();
    stall = 1'b1;
    ad = 24'($urandom);
    rs = 8'($urandom);
    val = {$urandom, $urandom, $urandom, $urandom};
    sz = 8'($urandom_range(16, 1));
    v = {8'h55, 8'hFB, 8'h07, 8'h06, ad[7:0], ad[15:8], ad[23:16], 8'h21, 8'h02, sz};
    frame(v);
    wait_hi(5);
    chk(176'(rd_cmd_o), 176'({ad, 8'h21, 8'h02, sz}), "read command");
    repeat (3) @(negedge core_clk_i);
    rd_cmd_ready_i = 1'b1;
    @(negedge core_clk_i);
    rd_cmd_ready_i = 1'b0;
    rd_reply(8'h00);
    rd_reply(8'hE1);
    v = {8'hFB, 8'h07 + sz, 8'h07, ad[7:0], ad[15:8], ad[23:16], 8'h30, 8'h01, sz};
    for (int i = 0; i < sz; i++) v.push_back(val[8*i +: 8]);
    frame(v);
    wait_hi(4);
    m = (128'h1 << (8 * sz)) - 128'h1;
    chk(176'(wr_cmd_o.value & m), 176'(val & m), "write value");
    chk(176'(wr_cmd_o[175:128]), 176'({ad, 8'h30, 8'h01, sz}), "write header");
    @(negedge core_clk_i);
    wr_cmd_ready_i = 1'b1;
    @(negedge core_clk_i);
    wr_cmd_ready_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      exp_q = {8'hFB, 8'h06, 8'h17, wst[i]};
      exp_q = {exp_q, ad[7:0], ad[15:8], ad[23:16], wrs[i]};
      wr_rep_i = '{wst[i], ad, wrs[i]};
      wr_rep_valid_i = 1'b1;
      wait_hi(2);
      @(negedge core_clk_i);
      wr_rep_valid_i = 1'b0;
      drain();
    end
    exp_q = {8'hFB, 8'h02, 8'h27, 8'hE1};
    frame({8'hFB, 8'h05, 8'h06, 8'h01, 8'h02, 8'h03, 8'h04});
    drain();
    event_out(7'($urandom_range(8, 1)));
    event_out(7'h6E);
    wrap_up();
  end
endmodule
